//--- verilog/wkc_consts.svh
// Offsets, field positions and reset values for the wake control bank
`ifndef WKC_CONSTS_SVH
`define WKC_CONSTS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define WKC_OFF_CTRL_STAT 8'h40
`define WKC_OFF_OPTIONS 8'h44
`define WKC_OFF_IRQ_STAT 8'h48
`define WKC_OFF_IRQ_MASK 8'h4C

// ----------------------------------------
// Field positions of the wake control/status register
// ----------------------------------------
`define WKC_BIT_STORE_WAKE 8
`define WKC_BIT_ADDR_SEEN 7
`define WKC_BIT_PATTERN_SEEN 6
`define WKC_BIT_MAGIC_SEEN 5
`define WKC_BIT_BCAST_SEEN 4
`define WKC_BIT_ADDR_EN 3
`define WKC_BIT_PATTERN_EN 2
`define WKC_BIT_MAGIC_EN 1
`define WKC_BIT_BROADCAST_WAKE_ENABLE 0
`define WKC_FLAGS_LSB 4
`define WKC_ENABLES_LSB 0

// ----------------------------------------
// Options register fields
// ----------------------------------------
`define WKC_BIT_RES_CLR_FLAGS 0
`define WKC_BIT_RES_CLR_EN 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define WKC_RST_CTRL 9'h000
`define WKC_RST_OPTIONS 2'h0
`define WKC_RST_IRQ 4'h0

`endif

//--- verilog/wkc_pkg.sv
// Types shared by the wake control bank
package wkc_pkg;

    // Receive storage state in deepest suspend
    typedef enum logic [2:0] {
        WKC_ST_PASS = 3'b001,
        WKC_ST_ARMED = 3'b010,
        WKC_ST_STORING = 3'b100
    } wkc_store_state_t;

    typedef logic [3:0] wkc_event_vec_t;

endpackage

//--- verilog/wkc_sticky_flags.sv
// Sticky event flags with write-one-to-clear and bulk clear
`timescale 1ns/10ps

module wkc_sticky_flags #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Set and clear
    input wire logic [WIDTH-1:0] set_pulse,
    input wire logic [WIDTH-1:0] clear_mask,
    input wire logic clear_all,
    // State
    output logic [WIDTH-1:0] flags
);

    genvar i;
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_flag
            // Set wins over any clear in the same cycle
            always_ff @(posedge clk_sys) begin
                if (reset) begin
                    flags[i] <= 1'b0;
                end else if (set_pulse[i]) begin
                    flags[i] <= 1'b1;
                end else if (clear_mask[i] || clear_all) begin
                    flags[i] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

//--- verilog/wkc_store_gate.sv
// Decides which received frames go to the receive FIFO after a wake
`timescale 1ns/10ps

module wkc_store_gate (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Mode
    input wire logic suspend_level_three,
    input wire logic store_wake,
    // Events
    input wire logic wake_by_frame,
    input wire logic wake_other,
    input wire logic resume_done,
    // Frame offered by the filters
    input wire logic frame_done,
    input wire logic frame_good,
    // Decision
    output logic frame_store
);
    import wkc_pkg::*;

    wkc_store_state_t state_reg;
    wkc_store_state_t state_next;

    // ----------------------------------------
    // Storage state
    // ----------------------------------------
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            WKC_ST_PASS: begin
                if (suspend_level_three) begin
                    state_next = WKC_ST_ARMED;
                end
            end
            WKC_ST_ARMED: begin
                if (!suspend_level_three) begin
                    state_next = WKC_ST_PASS;
                end else if (wake_by_frame || wake_other) begin
                    state_next = WKC_ST_STORING;
                end
            end
            WKC_ST_STORING: begin
                if (resume_done || !suspend_level_three) begin
                    state_next = WKC_ST_PASS;
                end
            end
            default: state_next = WKC_ST_PASS;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state_reg <= WKC_ST_PASS;
        end else begin
            state_reg <= state_next;
        end
    end

    // ----------------------------------------
    // Store decision, one cycle after the frame end
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            frame_store <= 1'b0;
        end else if (!frame_done) begin
            frame_store <= 1'b0;
        end else if (!suspend_level_three) begin
            // Level read directly so a stale state cannot leak past suspend exit
            frame_store <= frame_good; // [RULE4]
        end else begin
            case (state_reg)
                // In deepest suspend before the state arms, the option has no effect
                WKC_ST_PASS: frame_store <= frame_good; // [RULE4]
                // Waking frame kept only when asked for
                WKC_ST_ARMED: frame_store <= frame_good && wake_by_frame && store_wake; // [RULE1] [RULE2]
                // Every good frame after the wake is kept
                WKC_ST_STORING: frame_store <= frame_good; // [RULE1] [RULE2] [RULE3]
                default: frame_store <= 1'b0;
            endcase
        end
    end

endmodule

//--- verilog/wkc_wake_bank.sv
// Wake control and status register bank with receive storage gating
//
// Functional notes
// RULE1: With store-wake set, the waking frame and all later good filtered frames are stored.
// RULE2: With store-wake clear, only good filtered frames after the wake are stored.
// RULE3: A wake not caused by a frame leads to storing every later good frame.
// RULE4: Store-wake matters only in suspend level three and is ignored otherwise.
// RULE5: A valid frame to the own physical address sets the address-match flag.
// RULE6: A valid frame matching a wake pattern sets the pattern flag.
// RULE7: A valid magic packet sets the magic flag.
// RULE8: A valid broadcast frame sets the broadcast flag.
// RULE9: Resume completion clears the four flags when resume-clears-flags is set.
// RULE10: Resume completion clears the four enables when resume-clears-enables is set.
// RULE11: Address-match enable lets an own-address frame wake the device.
// RULE12: Pattern enable lets a programmed wake-pattern detection wake the device.
// RULE13: Magic enable puts the device in magic wake mode.
// RULE14: Broadcast enable lets a broadcast frame wake the device.
// RULE15: Software keeps all wake enables clear in normal operation.
// RULE16: Flags stay set until software writes one to them; zero leaves them.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/10ps
`include "wkc_consts.svh"

module wkc_wake_bank #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32,
    parameter int MAC_W = 48
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [DATA_W-1:0] reg_rdata,
    // Own physical address from the address registers
    input wire logic [31:0] own_address_low,
    input wire logic [15:0] own_address_high,
    // Receive frame path, one-cycle strobe at frame end
    input wire logic rx_frame_done,
    input wire logic rx_frame_ok,
    input wire logic rx_filter_pass,
    input wire logic [MAC_W-1:0] rx_dest_addr,
    input wire logic rx_pattern_hit,
    input wire logic rx_magic_hit,
    // Power state and other wake sources
    input wire logic suspend_level_three,
    input wire logic other_wake,
    input wire logic resume_done,
    // Results
    output logic rx_frame_store,
    output logic wake_request,
    output logic irq
);
    import wkc_pkg::*;

    localparam logic [MAC_W-1:0] BCAST_ADDR = {MAC_W{1'b1}};

    logic [3:0] enables_reg;
    logic store_wake_reg;
    logic res_clr_flags_reg;
    logic res_clr_en_reg;
    logic [3:0] irq_mask_reg;
    logic [3:0] irq_stat_reg;
    wkc_event_vec_t flags;
    wkc_event_vec_t hit;
    wkc_event_vec_t seen_set;
    wkc_event_vec_t wake_hit;
    logic [3:0] flag_wclr;
    logic frame_valid;
    logic frame_wake;
    logic [DATA_W-1:0] rdata_next;

    // Offset decode used by writes and reads
    function automatic logic sel(input logic [ADDR_W-1:0] a, input logic [7:0] off);
        sel = (a == ADDR_W'(off));
    endfunction

    // ----------------------------------------
    // Frame classification
    // ----------------------------------------
    assign frame_valid = rx_frame_done && rx_frame_ok;
    always_comb begin
        hit = 4'h0;
        hit[`WKC_BIT_ADDR_EN] = rx_dest_addr == {own_address_high, own_address_low}; // [RULE5]
        hit[`WKC_BIT_PATTERN_EN] = rx_pattern_hit; // [RULE6]
        hit[`WKC_BIT_MAGIC_EN] = rx_magic_hit; // [RULE7]
        hit[`WKC_BIT_BROADCAST_WAKE_ENABLE] = rx_dest_addr == BCAST_ADDR; // [RULE8]
    end
    assign seen_set = frame_valid ? hit : 4'h0;
    // Wake only on an enabled match; enables are expected clear in normal use [RULE15]
    assign wake_hit = seen_set & enables_reg; // [RULE11] [RULE12] [RULE13] [RULE14]
    assign frame_wake = |wake_hit;

    // ----------------------------------------
    // Received-event flags
    // ----------------------------------------
    always_comb begin
        flag_wclr = 4'h0;
        if (reg_write && sel(reg_addr, `WKC_OFF_CTRL_STAT)) begin
            flag_wclr = reg_wdata[`WKC_FLAGS_LSB +: 4]; // [RULE16]
        end
    end

    wkc_sticky_flags #(
        .WIDTH(4)
    ) u_flags (
        .clk_sys(clk_sys),
        .reset(reset),
        .set_pulse(seen_set), // [RULE5] [RULE6] [RULE7] [RULE8]
        .clear_mask(flag_wclr), // [RULE16]
        .clear_all(resume_done && res_clr_flags_reg), // [RULE9]
        .flags(flags)
    );

    // ----------------------------------------
    // Wake enables and store option
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            enables_reg <= 4'(`WKC_RST_CTRL);
        end else if (resume_done && res_clr_en_reg) begin
            // Resume clearing beats a write in the same cycle
            enables_reg <= 4'h0; // [RULE10]
        end else if (reg_write && sel(reg_addr, `WKC_OFF_CTRL_STAT)) begin
            enables_reg <= reg_wdata[`WKC_ENABLES_LSB +: 4];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            store_wake_reg <= 1'b0;
        end else if (reg_write && sel(reg_addr, `WKC_OFF_CTRL_STAT)) begin
            store_wake_reg <= reg_wdata[`WKC_BIT_STORE_WAKE];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            res_clr_flags_reg <= 1'b0;
            res_clr_en_reg <= 1'b0;
        end else if (reg_write && sel(reg_addr, `WKC_OFF_OPTIONS)) begin
            res_clr_flags_reg <= reg_wdata[`WKC_BIT_RES_CLR_FLAGS];
            res_clr_en_reg <= reg_wdata[`WKC_BIT_RES_CLR_EN];
        end
    end

    // ----------------------------------------
    // Receive storage decision
    // ----------------------------------------
    wkc_store_gate u_store (
        .clk_sys(clk_sys),
        .reset(reset),
        .suspend_level_three(suspend_level_three),
        .store_wake(store_wake_reg),
        .wake_by_frame(frame_wake),
        .wake_other(other_wake), // [RULE3]
        .resume_done(resume_done),
        .frame_done(rx_frame_done),
        .frame_good(rx_frame_ok && rx_filter_pass),
        .frame_store(rx_frame_store)
    );

    // ----------------------------------------
    // Wake request
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            wake_request <= 1'b0;
        end else begin
            wake_request <= frame_wake; // [RULE11] [RULE12] [RULE13] [RULE14]
        end
    end

    // ----------------------------------------
    // Interrupt status, mask and output
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_stat_reg <= `WKC_RST_IRQ;
        end else if (reg_read && sel(reg_addr, `WKC_OFF_IRQ_STAT)) begin
            // New events in the read cycle survive the clear
            irq_stat_reg <= seen_set;
        end else begin
            irq_stat_reg <= irq_stat_reg | seen_set;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_mask_reg <= `WKC_RST_IRQ;
        end else if (reg_write && sel(reg_addr, `WKC_OFF_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata[3:0];
        end
    end

    // Lags status by one cycle so the output stays a flop
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb begin
        rdata_next = '0;
        if (sel(reg_addr, `WKC_OFF_CTRL_STAT)) begin
            rdata_next[`WKC_BIT_STORE_WAKE] = store_wake_reg;
            rdata_next[`WKC_FLAGS_LSB +: 4] = flags;
            rdata_next[`WKC_ENABLES_LSB +: 4] = enables_reg;
        end else if (sel(reg_addr, `WKC_OFF_OPTIONS)) begin
            rdata_next[`WKC_BIT_RES_CLR_FLAGS] = res_clr_flags_reg;
            rdata_next[`WKC_BIT_RES_CLR_EN] = res_clr_en_reg;
        end else if (sel(reg_addr, `WKC_OFF_IRQ_STAT)) begin
            rdata_next[3:0] = irq_stat_reg;
        end else if (sel(reg_addr, `WKC_OFF_IRQ_MASK)) begin
            rdata_next[3:0] = irq_mask_reg;
        end
    end

    // Unmapped offsets and idle cycles read as zero
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

//--- verification/wkc_wake_bank_chk.sv
// Port-level concurrent checks for the wake control bank
`timescale 1ns/10ps
`include "wkc_consts.svh"

module wkc_wake_bank_chk #(
    parameter int ADDR_W = 8,
    parameter int DATA_W = 32,
    parameter int MAC_W = 48
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Register port
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic reg_read,
    input wire logic [DATA_W-1:0] reg_rdata,
    // Receive path and mode
    input wire logic [31:0] own_address_low,
    input wire logic [15:0] own_address_high,
    input wire logic rx_frame_done,
    input wire logic rx_frame_ok,
    input wire logic rx_filter_pass,
    input wire logic [MAC_W-1:0] rx_dest_addr,
    input wire logic rx_pattern_hit,
    input wire logic rx_magic_hit,
    input wire logic suspend_level_three,
    // Results
    input wire logic rx_frame_store,
    input wire logic wake_request,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (reset);

    logic good;
    logic hit;
    assign good = rx_frame_done && rx_frame_ok;
    assign hit = rx_pattern_hit || rx_magic_hit || (&rx_dest_addr)
        || rx_dest_addr == {own_address_high, own_address_low};

    a_rdata_idle: assert property (!reg_read |=> reg_rdata == '0)
        else $error("read data not idle");
    a_rdata_unmapped: assert property (reg_read && !(reg_addr inside {`WKC_OFF_CTRL_STAT,
        `WKC_OFF_OPTIONS, `WKC_OFF_IRQ_STAT, `WKC_OFF_IRQ_MASK}) |=> reg_rdata == '0)
        else $error("unmapped read not zero");
    a_ctrl_reserved: assert property (reg_read && reg_addr == `WKC_OFF_CTRL_STAT
        |=> reg_rdata[DATA_W-1:9] == '0) else $error("reserved bits set");
    a_store_awake: assert property (rx_frame_done && !suspend_level_three
        |=> rx_frame_store == $past(good && rx_filter_pass)) else $error("store wrong");
    a_store_bad: assert property (rx_frame_done && !(rx_frame_ok && rx_filter_pass)
        |=> !rx_frame_store) else $error("bad frame stored");
    a_store_cause: assert property (rx_frame_store |-> $past(good))
        else $error("store without frame");
    a_wake_cause: assert property (wake_request |-> $past(good && hit))
        else $error("wake without matching frame");
    a_irq_read_clear: assert property (reg_read && reg_addr == `WKC_OFF_IRQ_STAT
        && !rx_frame_done ##1 !rx_frame_done |=> ##1 !irq) else $error("irq not cleared");

    c_wake: cover property (wake_request);
    c_store_s3: cover property (rx_frame_store && suspend_level_three);
    c_irq: cover property ($rose(irq));
endmodule

bind wkc_wake_bank wkc_wake_bank_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W), .MAC_W(MAC_W)) i_chk (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .own_address_low(own_address_low),
    .own_address_high(own_address_high), .rx_frame_done(rx_frame_done),
    .rx_frame_ok(rx_frame_ok), .rx_filter_pass(rx_filter_pass), .rx_dest_addr(rx_dest_addr),
    .rx_pattern_hit(rx_pattern_hit), .rx_magic_hit(rx_magic_hit),
    .suspend_level_three(suspend_level_three), .rx_frame_store(rx_frame_store),
    .wake_request(wake_request), .irq(irq));

//--- verification/wkc_rx_model.sv
// Receive frame path model offering frames to the wake bank
`timescale 1ns/10ps

module wkc_rx_model (
    // Clock
    input wire logic clk_sys,
    // Frame end strobe and qualifiers
    output logic rx_frame_done,
    output logic rx_frame_ok,
    output logic rx_filter_pass,
    output logic [47:0] rx_dest_addr,
    output logic rx_pattern_hit,
    output logic rx_magic_hit
);
    initial begin
        rx_frame_done = 1'b0;
        {rx_frame_ok, rx_filter_pass, rx_pattern_hit, rx_magic_hit, rx_dest_addr} = '0;
    end

    // Qualifiers mean nothing outside the strobe, so they are inverted there
    task automatic send(input logic [47:0] d, input logic ok, ps, pt, mg);
        @(posedge clk_sys);
        rx_frame_done <= 1'b1;
        {rx_frame_ok, rx_filter_pass, rx_pattern_hit, rx_magic_hit, rx_dest_addr} <=
            {ok, ps, pt, mg, d};
        @(posedge clk_sys);
        rx_frame_done <= 1'b0;
        {rx_frame_ok, rx_filter_pass, rx_pattern_hit, rx_magic_hit, rx_dest_addr} <=
            ~{ok, ps, pt, mg, d};
    endtask
endmodule

//--- verification/wkc_wake_bank_tb_top.sv
// Self-checking bench for the wake control bank
`timescale 1ns/10ps

module wkc_wake_bank_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] own_address_low = 32'h0A0B_0C0D;
    logic [15:0] own_address_high = 16'h0E0F;
    logic rx_frame_done, rx_frame_ok, rx_filter_pass, rx_pattern_hit, rx_magic_hit;
    logic [47:0] rx_dest_addr;
    logic suspend_level_three = 1'b0;
    logic other_wake = 1'b0;
    logic resume_done = 1'b0;
    logic rx_frame_store, wake_request, irq;
    logic [3:0] en;
    logic [7:0] rst_offs [5] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h50};
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    always #5 clk_sys = ~clk_sys;

    wkc_rx_model i_rx (.clk_sys(clk_sys), .rx_frame_done(rx_frame_done),
        .rx_frame_ok(rx_frame_ok), .rx_filter_pass(rx_filter_pass),
        .rx_dest_addr(rx_dest_addr), .rx_pattern_hit(rx_pattern_hit),
        .rx_magic_hit(rx_magic_hit));

    wkc_wake_bank i_dut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .own_address_low(own_address_low),
        .own_address_high(own_address_high), .rx_frame_done(rx_frame_done),
        .rx_frame_ok(rx_frame_ok), .rx_filter_pass(rx_filter_pass), .rx_dest_addr(rx_dest_addr),
        .rx_pattern_hit(rx_pattern_hit), .rx_magic_hit(rx_magic_hit),
        .suspend_level_three(suspend_level_three), .other_wake(other_wake),
        .resume_done(resume_done), .rx_frame_store(rx_frame_store),
        .wake_request(wake_request), .irq(irq));

    // ------
    // Helpers
    // ------
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Expected control/status word from its three fields
    function automatic logic [31:0] ctrl_word(input logic sw, input logic [3:0] fl,
        input logic [3:0] e);
        return {23'h0, sw, fl, e};
    endfunction

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {reg_addr, reg_wdata, reg_write} <= {a, d, 1'b1};
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        {reg_addr, reg_read} <= {a, 1'b1};
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 chk("rdata", reg_rdata, e);
    endtask

    // Kind 0 broadcast, 1 magic, 2 pattern, 3 own address, 4 plain unicast
    task automatic fr(input int k, input logic ok, input logic ps);
        logic [47:0] d;
        d = (k == 0) ? 48'hFFFF_FFFF_FFFF : (k == 3) ? {own_address_high, own_address_low}
            : 48'h0200_0000_0001;
        i_rx.send(d, ok, ps, k == 2, k == 1);
        #1;
    endtask

    task automatic pulse(input logic oth);
        @(posedge clk_sys);
        {other_wake, resume_done} <= {oth, !oth};
        @(posedge clk_sys);
        {other_wake, resume_done} <= 2'b00;
    endtask

    task automatic st(input int k, input logic ps, input logic e);
        fr(k, 1'b1, ps);
        chk("store", 32'(rx_frame_store), 32'(e));
    endtask

    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_mismatch++;
            print_verdict;
        end
    end

    // ------
    // Main sequence
    // ------
    initial begin
        void'($urandom(32'hAD64));
        repeat (10) @(posedge clk_sys);
        reset <= 1'b0;
        foreach (rst_offs[i]) rd(rst_offs[i], 32'h0);
        wr(8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0000_010F);
        wr(8'h40, 32'h0);
        for (int k = 0; k < 4; k++) begin
            en = 4'($urandom);
            wr(8'h40, {28'h0, en});
            wr(8'h4C, 32'h1 << k);
            fr(k, 1'b0, 1'b1);
            chk("wake_bad", 32'(wake_request), 32'h0);
            rd(8'h40, {28'h0, en});
            fr(k, 1'b1, 1'b1);
            chk("wake", 32'(wake_request), 32'(en[k]));
            chk("store", 32'(rx_frame_store), 32'h1);
            wr(8'h40, {28'h0, en});
            rd(8'h40, ctrl_word(1'b0, 4'h1 << k, en));
            chk("irq", 32'(irq), 32'h1);
            rd(8'h48, 32'h1 << k);
            rd(8'h48, 32'h0);
            chk("irq_clr", 32'(irq), 32'h0);
            wr(8'h40, 32'h10 << k);
            rd(8'h40, 32'h0);
        end
        wr(8'h40, 32'h10F);
        fr(0, 1'b1, 1'b1);
        wr(8'h44, 32'h1);
        pulse(1'b0);
        rd(8'h40, 32'h10F);
        fr(0, 1'b1, 1'b1);
        wr(8'h44, 32'h2);
        pulse(1'b0);
        rd(8'h40, 32'h110);
        wr(8'h44, 32'h1);
        pulse(1'b0);
        rd(8'h40, 32'h100);
        wr(8'h44, 32'h0);
        wr(8'h40, 32'h101);
        @(posedge clk_sys);
        suspend_level_three <= 1'b1;
        st(1, 1'b1, 1'b0);
        st(0, 1'b1, 1'b1);
        st(4, 1'b1, 1'b1);
        pulse(1'b0);
        wr(8'h40, 32'h1);
        st(0, 1'b1, 1'b0);
        st(4, 1'b1, 1'b1);
        pulse(1'b0);
        pulse(1'b1);
        st(4, 1'b1, 1'b1);
        pulse(1'b0);
        st(4, 1'b1, 1'b0);
        wr(8'h40, 32'h100);
        @(posedge clk_sys);
        suspend_level_three <= 1'b0;
        st(4, 1'b1, 1'b1);
        st(4, 1'b0, 1'b0);
        wr(8'h40, 32'h0);
        print_verdict;
    end
endmodule
